// ===== rtl/iof_filter_top.sv
// IMU output boxcar filter and integration configuration, top level.
// Assumes samples arrive on the reference clock, one scalar per sample,
// with the estimator's live bias for that sensor alongside.
`timescale 1ns/1ps
`default_nettype none
module iof_filter_top (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Incoming sensor samples
    input wire logic sample_valid_in,
    input wire logic [2:0] sample_sensor_in,
    input wire logic [15:0] sample_raw_in,
    input wire logic [15:0] sample_comp_in,
    input wire logic [15:0] sample_bias_in,
    output logic sample_ready_out,
    // Register byte port
    input wire logic reg_sel_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Unaveraged samples to the estimation filter
    output logic est_valid_out,
    output logic [2:0] est_sensor_out,
    output logic [15:0] est_raw_out,
    output logic [15:0] est_comp_out,
    // Reported output samples
    output logic out_valid_out,
    output logic [2:0] out_sensor_out,
    output logic [15:0] out_raw_out,
    output logic [15:0] out_comp_out,
    // Coning and sculling inputs
    output logic integ_valid_out,
    output logic [2:0] integ_sensor_out,
    output logic [15:0] integ_data_out,
    output logic [7:0] integ_frame_out,
    output logic integ_use_attitude_out
);
    typedef struct packed {
        iof_pkg::iof_state_t state;
        logic [4:0][15:0] win_len;
        logic [4:0][7:0] mode;
        logic [7:0] frame;
        logic [7:0] rate_comp;
        logic [7:0] accel_comp;
        logic [9:0][23:0] sum;
        logic [9:0][5:0] wp;
        logic [9:0][6:0] fill;
        logic [2:0] sensor;
        logic [15:0] raw;
        logic [15:0] comp;
        logic stream;
        logic filt;
        logic neg;
        logic [23:0] divisor;
        logic [23:0] rem;
        logic [23:0] quo;
        logic [4:0] div_cnt;
        logic [15:0] res_raw;
        logic [7:0] rdata;
        logic rvalid;
        logic est_valid;
        logic [2:0] est_sensor;
        logic [15:0] est_raw;
        logic [15:0] est_comp;
        logic out_valid;
        logic [2:0] out_sensor;
        logic [15:0] out_raw;
        logic [15:0] out_comp;
        logic integ_valid;
        logic [2:0] integ_sensor;
        logic [15:0] integ_data;
        logic [7:0] integ_frame;
        logic integ_attitude;
    } iof_top_state_t;

    iof_top_state_t q;
    iof_top_state_t d;

    // Working signals of the datapath
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [50:0] fifo_out_data;
    logic mem_we;
    logic [9:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [3:0] cur_idx;
    logic [6:0] win;
    logic [15:0] x;
    logic [23:0] sum_new;
    logic [23:0] rem_sh;
    logic [6:0] cnt;
    logic [15:0] val;
    logic [2:0] in_sensor;
    logic [15:0] in_raw;
    logic [15:0] in_comp;
    logic [15:0] in_bias;
    logic [3:0] lane;

    // Effective window: zero and one mean pass-through, storage caps it at 64
    function automatic logic [6:0] iof_window(input logic [15:0] len);
        logic [6:0] w;
        w = len[6:0];
        if (len <= 16'h0001) begin
            w = 7'h01;
        end else if (len > {9'h000, iof_pkg::WINDOW_MAX}) begin
            w = iof_pkg::WINDOW_MAX;
        end
        return w;
    endfunction : iof_window

    // History slot of one stream: each stream owns 64 consecutive words
    function automatic logic [9:0] iof_hist_addr(input logic [3:0] idx, input logic [5:0] ptr);
        return {idx, ptr};
    endfunction : iof_hist_addr

    // Sign-extend a sample to accumulator width
    function automatic logic [23:0] iof_extend(input logic [15:0] v);
        return {{8{v[15]}}, v};
    endfunction : iof_extend

    iof_fifo #(
        .WIDTH(iof_pkg::FIFO_W),
        .DEPTH(iof_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(sample_valid_in),
        .in_data_in({sample_sensor_in, sample_raw_in, sample_comp_in, sample_bias_in}),
        .in_ready_out(sample_ready_out),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(fifo_out_ready)
    );

    iof_hist_mem #(
        .WIDTH(iof_pkg::SAMPLE_W),
        .DEPTH(iof_pkg::MEM_DEPTH),
        .ADDR_W(iof_pkg::MEM_ADDR_W)
    ) u_hist (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .we_in(mem_we),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    // Unpack the FIFO word
    assign in_sensor = fifo_out_data[50:48];
    assign in_raw = fifo_out_data[47:32];
    assign in_comp = fifo_out_data[31:16];
    assign in_bias = fifo_out_data[15:0];

    // Sample sequencer, divider and register port
    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        d.est_valid = 1'b0;
        d.out_valid = 1'b0;
        d.integ_valid = 1'b0;
        fifo_out_ready = 1'b0;
        cur_idx = {q.sensor, q.stream};
        win = iof_window(q.win_len[q.sensor]);
        x = q.stream ? q.comp : q.raw;
        mem_we = 1'b0;
        mem_addr = iof_hist_addr(cur_idx, q.wp[cur_idx] - win[5:0]);
        mem_wdata = x;
        sum_new = q.sum[cur_idx];
        rem_sh = {q.rem[22:0], q.quo[23]};
        cnt = win;
        val = x;
        lane = 4'h0;

        case (q.state)
            iof_pkg::ST_IDLE: begin
                fifo_out_ready = 1'b1;
                if (fifo_out_valid) begin
                    d.sensor = in_sensor;
                    d.raw = in_raw;
                    d.comp = in_comp;
                    d.stream = 1'b0;
                    // Estimator copy leaves before any averaging
                    d.est_valid = 1'b1;
                    d.est_sensor = in_sensor;
                    d.est_raw = in_raw;
                    d.est_comp = in_comp;
                    // Unknown sensor codes go to the estimator only
                    if (in_sensor <= iof_pkg::SENSOR_PRES) begin
                        d.state = iof_pkg::ST_READ;
                    end
                    // One integration input per rate or accel sample
                    if (in_sensor == iof_pkg::SENSOR_GYRO) begin
                        d.integ_valid = 1'b1;
                        d.integ_sensor = in_sensor;
                        if (q.rate_comp == iof_pkg::COMP_BIAS) begin
                            d.integ_data = in_raw - in_bias;
                        end else begin
                            d.integ_data = in_raw;
                        end
                    end else if (in_sensor == iof_pkg::SENSOR_ACCEL) begin
                        d.integ_valid = 1'b1;
                        d.integ_sensor = in_sensor;
                        if (q.accel_comp == iof_pkg::COMP_BIAS) begin
                            d.integ_data = in_raw - in_bias;
                        end else begin
                            d.integ_data = in_raw;
                        end
                    end
                    d.integ_frame = q.frame;
                    d.integ_attitude = (q.frame != iof_pkg::FRAME_BODY);
                end
            end
            iof_pkg::ST_READ: begin
                // Fetch the oldest sample; data returns next cycle
                d.state = iof_pkg::ST_UPDATE;
            end
            iof_pkg::ST_UPDATE: begin
                // Running sum: add newest, drop the oldest
                if (q.fill[cur_idx] >= win) begin
                    sum_new = q.sum[cur_idx] + iof_extend(x) - iof_extend(mem_rdata);
                end else begin
                    sum_new = q.sum[cur_idx] + iof_extend(x);
                    d.fill[cur_idx] = q.fill[cur_idx] + 7'h01;
                    cnt = q.fill[cur_idx] + 7'h01;
                end
                d.sum[cur_idx] = sum_new;
                mem_we = 1'b1;
                mem_addr = iof_hist_addr(cur_idx, q.wp[cur_idx]);
                d.wp[cur_idx] = q.wp[cur_idx] + 6'h01;
                d.neg = sum_new[23];
                d.quo = sum_new[23] ? (24'h00_0000 - sum_new) : sum_new;
                d.rem = 24'h00_0000;
                d.divisor = {17'h0_0000, cnt};
                d.div_cnt = iof_pkg::DIV_STEPS;
                // Mode bit per stream enables averaging
                d.filt = q.mode[q.sensor][q.stream] && (win > 7'h01);
                d.state = d.filt ? iof_pkg::ST_DIVIDE : iof_pkg::ST_DONE;
            end
            iof_pkg::ST_DIVIDE: begin
                // Restoring divide, one quotient bit per cycle; slow is fine
                // with 100000 cycles between samples
                d.quo = {q.quo[22:0], 1'b0};
                if (rem_sh >= q.divisor) begin
                    d.rem = rem_sh - q.divisor;
                    d.quo[0] = 1'b1;
                end else begin
                    d.rem = rem_sh;
                end
                d.div_cnt = q.div_cnt - 5'h01;
                if (q.div_cnt == 5'h01) begin
                    d.state = iof_pkg::ST_DONE;
                end
            end
            iof_pkg::ST_DONE: begin
                if (q.filt) begin
                    val = q.neg ? (16'h0000 - q.quo[15:0]) : q.quo[15:0];
                end
                if (!q.stream) begin
                    d.res_raw = val;
                    d.stream = 1'b1;
                    d.state = iof_pkg::ST_READ;
                end else begin
                    d.out_valid = 1'b1;
                    d.out_sensor = q.sensor;
                    d.out_raw = q.res_raw;
                    d.out_comp = val;
                    d.state = iof_pkg::ST_IDLE;
                end
            end
            default: begin
                d.state = iof_pkg::ST_IDLE;
            end
        endcase

        // Register writes; a length write restarts that sensor's history
        if (reg_wr_in) begin
            if (reg_sel_in == iof_pkg::REG_SEL_FILTER) begin
                if (reg_addr_in < iof_pkg::OFS_MODE_BASE) begin
                    lane = {1'b0, reg_addr_in[3:1]};
                    if (reg_addr_in[0]) begin
                        d.win_len[lane[2:0]][15:8] = reg_wdata_in;
                    end else begin
                        d.win_len[lane[2:0]][7:0] = reg_wdata_in;
                    end
                    d.sum[{lane[2:0], 1'b0}] = 24'h00_0000;
                    d.sum[{lane[2:0], 1'b1}] = 24'h00_0000;
                    d.fill[{lane[2:0], 1'b0}] = 7'h00;
                    d.fill[{lane[2:0], 1'b1}] = 7'h00;
                end else if (reg_addr_in < iof_pkg::OFS_FILTER_END) begin
                    lane = reg_addr_in - iof_pkg::OFS_MODE_BASE;
                    d.mode[lane[2:0]] = reg_wdata_in;
                end
            end else begin
                if (reg_addr_in == iof_pkg::OFS_FRAME) begin
                    d.frame = reg_wdata_in;
                end else if (reg_addr_in == iof_pkg::OFS_RATE_COMP) begin
                    d.rate_comp = reg_wdata_in;
                end else if (reg_addr_in == iof_pkg::OFS_ACCEL_COMP) begin
                    d.accel_comp = reg_wdata_in;
                end
                // Reserved bytes are expected as zero and are not stored
            end
        end

        // Reads answer a cycle later; unmapped bytes read zero
        if (reg_rd_in) begin
            d.rvalid = 1'b1;
            d.rdata = 8'h00;
            if (reg_sel_in == iof_pkg::REG_SEL_FILTER) begin
                if (reg_addr_in < iof_pkg::OFS_MODE_BASE) begin
                    if (reg_addr_in[0]) begin
                        d.rdata = q.win_len[reg_addr_in[3:1]][15:8];
                    end else begin
                        d.rdata = q.win_len[reg_addr_in[3:1]][7:0];
                    end
                end else if (reg_addr_in < iof_pkg::OFS_FILTER_END) begin
                    lane = reg_addr_in - iof_pkg::OFS_MODE_BASE;
                    d.rdata = q.mode[lane[2:0]];
                end
            end else begin
                if (reg_addr_in == iof_pkg::OFS_FRAME) begin
                    d.rdata = q.frame;
                end else if (reg_addr_in == iof_pkg::OFS_RATE_COMP) begin
                    d.rdata = q.rate_comp;
                end else if (reg_addr_in == iof_pkg::OFS_ACCEL_COMP) begin
                    d.rdata = q.accel_comp;
                end
            end
        end
    end

    // State register; configuration resets to the factory values
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
            q.win_len <= iof_pkg::LEN_RESET;
            q.mode <= iof_pkg::MODE_RESET;
            q.frame <= iof_pkg::INTEG_RESET;
            q.rate_comp <= iof_pkg::INTEG_RESET;
            q.accel_comp <= iof_pkg::INTEG_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out = q.rdata;
    assign reg_rvalid_out = q.rvalid;
    assign est_valid_out = q.est_valid;
    assign est_sensor_out = q.est_sensor;
    assign est_raw_out = q.est_raw;
    assign est_comp_out = q.est_comp;
    assign out_valid_out = q.out_valid;
    assign out_sensor_out = q.out_sensor;
    assign out_raw_out = q.out_raw;
    assign out_comp_out = q.out_comp;
    assign integ_valid_out = q.integ_valid;
    assign integ_sensor_out = q.integ_sensor;
    assign integ_data_out = q.integ_data;
    assign integ_frame_out = q.integ_frame;
    assign integ_use_attitude_out = q.integ_attitude;
endmodule : iof_filter_top
`default_nettype wire

// ===== inc/iof_pkg.sv
// Constants, field layouts, reset values and types of the IMU output filter.
// Assumes one reference clock and samples delivered one scalar at a time.
// Functional notes
// - Output samples are averaged over an equal-weight window of configurable length.
// - Averaging touches only reported outputs; estimator samples stay unaveraged.
// - Each sensor's window length counts samples taken at the 400 Hz IMU rate.
// - Every sensor has its own mode choosing which outputs get averaged.
// - Mode 0 none, 1 raw only, 2 compensated only, 3 both.
// - Compensated stream is iron-corrected, bias-removed estimator data.
// - Coning and sculling inputs are produced once per IMU sample at 400 Hz.
// - Integration frame: 0 body, 1 north-east-down, 2 earth-centred earth-fixed.
// - Non-body integration frames use the estimator's attitude for conversion.
// - After reset the integration frame is the sensor body frame.
// - Rate compensation 0 none, 1 bias; bias subtracts live gyro bias estimate.
// - After reset angular rates are integrated uncompensated.
// - Accel compensation 0 none, 1 bias; bias subtracts live accel bias estimate.
// - After reset acceleration is integrated uncompensated.
// - Integration config is six bytes: frame, rate comp, accel comp, three reserved.
// - Filter config holds five 16-bit window lengths and five 8-bit modes.
package iof_pkg;

    // Data widths and sensor numbering
    localparam int SAMPLE_W = 16;
    localparam int SENSOR_W = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 51;
    localparam logic [2:0] SENSOR_MAG = 3'h0;
    localparam logic [2:0] SENSOR_ACCEL = 3'h1;
    localparam logic [2:0] SENSOR_GYRO = 3'h2;
    localparam logic [2:0] SENSOR_TEMP = 3'h3;
    localparam logic [2:0] SENSOR_PRES = 3'h4;

    // History memory: 64 samples per stream, ten streams
    localparam int MEM_DEPTH = 640;
    localparam int MEM_ADDR_W = 10;
    localparam logic [6:0] WINDOW_MAX = 7'h40;
    localparam logic [4:0] DIV_STEPS = 5'h18;

    // Sample rate against the clock
    localparam int IMU_RATE_HZ = 400;
    localparam int REF_CLK_HZ = 40_000_000;
    localparam int SAMPLE_PERIOD_CYCLES = REF_CLK_HZ / IMU_RATE_HZ;

    // Register selection and byte offsets
    localparam logic REG_SEL_FILTER = 1'b0;
    localparam logic REG_SEL_INTEG = 1'b1;
    localparam logic [3:0] OFS_LEN_BASE = 4'h0;
    localparam logic [3:0] OFS_MODE_BASE = 4'hA;
    localparam logic [3:0] OFS_FILTER_END = 4'hF;
    localparam logic [3:0] OFS_FRAME = 4'h0;
    localparam logic [3:0] OFS_RATE_COMP = 4'h1;
    localparam logic [3:0] OFS_ACCEL_COMP = 4'h2;
    localparam logic [3:0] OFS_RSVD_THREE = 4'h3;
    localparam logic [3:0] OFS_RSVD_FOUR = 4'h4;

    // Field encodings
    localparam int MODE_RAW_BIT = 0;
    localparam int MODE_COMP_BIT = 1;
    localparam logic [7:0] FRAME_BODY = 8'h00;
    localparam logic [7:0] FRAME_NORTH_EAST_DOWN = 8'h01;
    localparam logic [7:0] FRAME_EARTH_CENTRED = 8'h02;
    localparam logic [7:0] COMP_NONE = 8'h00;
    localparam logic [7:0] COMP_BIAS = 8'h01;

    // Reset values, index 0 is magnetic, 4 is pressure
    localparam logic [4:0][15:0] LEN_RESET = {16'h0000, 16'h0004, 16'h0004, 16'h0004, 16'h0000};
    localparam logic [4:0][7:0] MODE_RESET = {8'h00, 8'h03, 8'h03, 8'h03, 8'h00};
    localparam logic [7:0] INTEG_RESET = 8'h00;

    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_UPDATE, ST_DIVIDE, ST_DONE} iof_state_t;

endpackage : iof_pkg

// ===== rtl/iof_fifo.sv
// Sample FIFO with valid and ready on both sides.
// Assumes both sides run on the same clock; ready on the fill side is registered.
`timescale 1ns/1ps
`default_nettype none
module iof_fifo #(
    parameter int WIDTH = 51,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
        logic ready;
    } iof_fifo_state_t;

    iof_fifo_state_t q;
    iof_fifo_state_t d;
    logic push;
    logic pop;

    // Pointers and count; ready is precomputed to leave a flop
    always_comb begin
        d = q;
        push = in_valid_in && q.ready;
        pop = out_ready_in && (q.count != '0);
        if (push) begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr = q.wr_ptr + 1'b1;
        end
        if (pop) begin
            d.rd_ptr = q.rd_ptr + 1'b1;
        end
        d.count = q.count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        d.ready = (d.count != DEPTH[PTR_W:0]);
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready_out = q.ready;
    assign out_valid_out = (q.count != '0);
    assign out_data_out = q.mem[q.rd_ptr];
endmodule : iof_fifo
`default_nettype wire

// ===== rtl/iof_hist_mem.sv
// Single-port history memory with registered read data.
// Assumes read and write are never needed in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module iof_hist_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 640,
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Access port
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] rdata_out
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } iof_mem_state_t;

    iof_mem_state_t q;
    iof_mem_state_t d;

    // Unreset contents are guarded by the fill counts
    always_comb begin
        d = q;
        d.rdata = q.mem[addr_in];
        if (we_in) begin
            d.mem[addr_in] = wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q.rdata <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata_out = q.rdata;
endmodule : iof_hist_mem
`default_nettype wire

// ===== testbench/iof_filter_props.sv
// Port checker for the IMU output filter top.
// Bound onto iof_filter_top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module iof_filter_props (
    // Watched ports
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic reg_sel_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic est_valid_out,
    input wire logic integ_valid_out,
    input wire logic [2:0] integ_sensor_out,
    input wire logic [7:0] integ_frame_out,
    input wire logic integ_use_attitude_out
);
    // Reset masks every check
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("no read answer");
    chk_no_stray_answer: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("stray read answer");
    chk_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    chk_reserved_zero: assert property (reg_rd_in && reg_sel_in && reg_addr_in > 4'h2
        && reg_addr_in < 4'h6 |=> reg_rdata_out == 8'h00) else $error("reserved not zero");
    chk_filter_gap_zero: assert property (reg_rd_in && !reg_sel_in && reg_addr_in == 4'hF
        |=> reg_rdata_out == 8'h00) else $error("unmapped not zero");
    chk_attitude_use: assert property (integ_use_attitude_out == (integ_frame_out != 8'h00))
        else $error("attitude flag wrong");
    chk_integ_sensor: assert property (integ_valid_out |-> integ_sensor_out inside {3'h1, 3'h2})
        else $error("integration sensor wrong");
    chk_frame_on_est: assert property (!est_valid_out |-> $stable(integ_frame_out))
        else $error("frame moved off a sample");
endmodule : iof_filter_props
`default_nettype wire

// ===== testbench/iof_sensor_src.sv
// Sensor sample source facing the filter's sample port.
// Caller runs just after a rising edge of the clock.
`timescale 1ns/1ps
`default_nettype none
module iof_sensor_src #(parameter int GAP = 1) (
    // Clock and handshake
    input wire logic clk_in,
    input wire logic ready_in,
    // Offered sample
    output logic valid_out,
    output logic [2:0] sensor_out,
    output logic [15:0] raw_out,
    output logic [15:0] comp_out,
    output logic [15:0] bias_out
);
    // Idle lines at time zero
    initial {valid_out, sensor_out, raw_out, comp_out, bias_out} = '0;
    // Hold until taken; released lines show inverted data
    task automatic send(input logic [2:0] s, input logic [15:0] r, c, b, output bit ok);
        repeat (GAP) @(posedge clk_in);
        #1 {valid_out, sensor_out, raw_out, comp_out, bias_out} = {1'b1, s, r, c, b};
        for (int n = 0; n < 2000 && !ready_in; n++) @(posedge clk_in) #1;
        ok = ready_in;
        @(posedge clk_in) #1 valid_out = 1'b0;
        {sensor_out, raw_out, comp_out, bias_out} = ~{s, r, c, b};
    endtask : send
endmodule : iof_sensor_src
`default_nettype wire

// ===== testbench/iof_filter_top_test.sv
// Self-checking bench for the IMU output filter top.
// Registers driven directly; samples come from the source model.
`timescale 1ns/1ps
`default_nettype none
module iof_filter_top_test;
    // Nets named as the filter ports
    logic ref_clk_in = 1'b0, reset_n_in = 1'b0, reg_sel_in = 1'b0, reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0, sample_valid_in, sample_ready_out, reg_rvalid_out, est_valid_out;
    logic out_valid_out, integ_valid_out, integ_use_attitude_out;
    logic [2:0] sample_sensor_in, est_sensor_out, out_sensor_out, integ_sensor_out;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, integ_frame_out;
    logic [15:0] sample_raw_in, sample_comp_in, sample_bias_in, est_raw_out, est_comp_out;
    logic [15:0] out_raw_out, out_comp_out, integ_data_out;
    int failures = 0, n_tests = 0, n_out = 0, n_est = 0, n_full = 0;
    bit ok;
    iof_filter_top dut (.*);
    iof_sensor_src src (.clk_in(ref_clk_in), .ready_in(sample_ready_out),
        .valid_out(sample_valid_in), .sensor_out(sample_sensor_in), .raw_out(sample_raw_in),
        .comp_out(sample_comp_in), .bias_out(sample_bias_in));
    // 40 MHz clock
    always #12.5 ref_clk_in = ~ref_clk_in;
    // Pulse and refusal counters
    always @(posedge ref_clk_in) begin
        n_out <= n_out + int'(out_valid_out);
        n_est <= n_est + int'(est_valid_out);
        n_full <= n_full + int'(!sample_ready_out);
    end
    // Compare and report
    task automatic check(input logic [47:0] got, exp);
        n_tests++;
        if (got !== exp) failures++;
        if (got !== exp) $display("Error %0t got %h exp %h", $time, got, exp);
    endtask : check
    // Verdict
    task automatic end_sim();
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Register write; an idle edge keeps strobes apart
    task automatic wr(input logic s, input logic [3:0] a, input logic [7:0] d);
        {reg_sel_in, reg_addr_in, reg_wdata_in, reg_wr_in} = {s, a, d, 1'b1};
        @(posedge ref_clk_in) #1 reg_wr_in = 1'b0;
        @(posedge ref_clk_in) #1;
    endtask : wr
    // Register read, judged in the answer cycle
    task automatic rd(input logic s, input logic [3:0] a, input logic [7:0] e);
        {reg_sel_in, reg_addr_in, reg_rd_in} = {s, a, 1'b1};
        @(posedge ref_clk_in) #1 reg_rd_in = 1'b0;
        check({reg_rvalid_out, reg_rdata_out}, {1'b1, e});
        @(posedge ref_clk_in) #1;
    endtask : rd
    // One sample; optionally wait for its report
    task automatic put(input logic [2:0] s, input logic [15:0] r, c, b, input bit w);
        int k;
        k = n_out + 1;
        src.send(s, r, c, b, ok);
        for (int i = 0; w && i < 2000 && n_out < k; i++) @(posedge ref_clk_in) #1;
        ok = ok && (!w || n_out >= k);
        if (!ok) failures++;
        if (!ok) end_sim();
    endtask : put
    // Reset values and the unmapped filter byte
    task automatic t_reset();
        for (int k = 0; k < 5; k++) begin
            rd(1'b0, 4'(2 * k), (k == 0 || k == 4) ? 8'h00 : 8'h04);
            rd(1'b0, 4'(10 + k), (k == 0 || k == 4) ? 8'h00 : 8'h03);
            rd(1'b1, 4'(k), 8'h00);
        end
        rd(1'b0, 4'hF, 8'h00);
    endtask : t_reset
    // Frames, rate bias removal, refused reserved write
    task automatic t_integ();
        logic [24:0] e;
        for (int f = 0; f < 3; f++) begin
            wr(1'b1, 4'h0, 8'(f));
            wr(1'b1, 4'h1, 8'(f));
            put(3'h2, 16'h0032, 16'h0000, 16'h0008, 1'b1);
            e = {8'(f), f != 0, f == 1 ? 16'h002A : 16'h0032};
            check({integ_frame_out, integ_use_attitude_out, integ_data_out}, e);
        end
        wr(1'b1, 4'h3, 8'h00);
        wr(1'b1, 4'h4, 8'h5A);
        rd(1'b1, 4'h4, 8'h00);
    endtask : t_integ
    // All modes on two accel samples, then a one-sample window
    task automatic t_modes();
        logic [15:0] ar, ac;
        for (int m = 0; m < 5; m++) begin
            wr(1'b0, 4'h2, m == 4 ? 8'h01 : 8'h02);
            wr(1'b0, 4'hB, m == 4 ? 8'h03 : 8'(m));
            put(3'h1, 16'h0002, 16'h0010, 16'h0000, 1'b1);
            put(3'h1, 16'h0006, 16'h0020, 16'h0000, 1'b1);
            ar = (m % 2 == 1 && m < 4) ? 16'h0004 : 16'h0006;
            ac = (m > 1 && m < 4) ? 16'h0018 : 16'h0020;
            check({out_raw_out, out_comp_out, est_raw_out}, {ar, ac, 16'h0006});
        end
    endtask : t_modes
    // Fill the FIFO until it refuses, then drain
    task automatic t_fifo();
        int e, f;
        e = n_est + 24;
        f = n_full;
        for (int i = 0; i < 24; i++) put(3'h3, 16'(i), 16'(i), 16'h0000, 1'b0);
        for (int i = 0; i < 3000 && n_est < e; i++) @(posedge ref_clk_in) #1;
        check(n_est, e);
        check(n_full > f, 1'b1);
    endtask : t_fifo
    // Six reset cycles, then the scenarios
    initial begin
        repeat (6) @(posedge ref_clk_in);
        #1 reset_n_in = 1'b1;
        t_reset();
        t_integ();
        t_modes();
        t_fifo();
        end_sim();
    end
endmodule : iof_filter_top_test
bind iof_filter_top iof_filter_props chk (.*);
`default_nettype wire
